// ==== flash_secure.sv ====
// Flash security gating and lockout recovery logic
// Assumes a flash model outside that performs the mass erase and reports done;
// JTAG instruction and data scans arrive already decoded as strobes on CORE_CLK.
//
// Function
// RULE1 - Security is decided only by the two stored security bytes.
// RULE2 - The state comes from non-volatile bytes, so it returns after every reset until they change.
// RULE3 - At boot the block picks exactly one mode: unsecured, or secure with debug disabled.
// RULE4 - When secure the debug port is disabled while normal execution is untouched.
// RULE5 - A core input blocks every debug-port read of internal memory when set.
// RULE6 - The debug-read disable is set during reset from the security bytes and held to the next reset; reset forces it set, bytes are sampled just after.
// RULE7 - The chip-level JTAG port stays active for boundary scan and ID in both modes.
// RULE8 - Lockout recovery erases the whole flash, which leaves the device unsecured.
// RULE9 - The lockout instruction selects a 7-bit data register that sets the erase timing divider.
// RULE10 - The host shifts a suitable divider value before starting the erase.
// RULE11 - During recovery the shifted value replaces the divider: bit 6 prescale, bits 5 to 0 divider.
// RULE12 - The host picks values that give a 150 kHz to 200 kHz timing clock.
// RULE13 - The host keeps the instruction selected until the erase ends, then resets the device.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "flash_secure_regs.svh"

module flash_secure
	import flash_secure_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                   CORE_CLK,
	input  wire logic                   RESET_N,
	input  wire logic                   CLK_EN,
	// Stored security bytes from the flash configuration field
	input  wire logic [7:0]             SEC_BYTE0,
	input  wire logic [7:0]             SEC_BYTE1,
	// JTAG side, decoded
	input  wire logic [`IR_WIDTH-1:0]   JTAG_IR,
	input  wire logic                   JTAG_DR_UPDATE,
	input  wire logic [`DIV_WIDTH-1:0]  JTAG_DR_IN,
	input  wire logic                   JTAG_RUN_ERASE,
	// Flash module side
	input  wire logic [`DIV_WIDTH-1:0]  NORMAL_DIVIDER,
	input  wire logic                   ERASE_DONE,
	output logic [`DIV_WIDTH-1:0]       FLASH_DIVIDER,
	output logic                        MASS_ERASE_REQ,
	// Core and debug
	output logic                        DEBUG_READ_DISABLE,
	output logic                        DEBUG_PORT_ENABLE,
	output logic                        TAP_ENABLE,
	// Register port
	input  wire logic [7:0]             REG_ADDR,
	input  wire logic [31:0]            REG_WDATA,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	output logic [31:0]                 REG_RDATA
);

	sec_regs_t q;
	sec_regs_t d;

	// Secured unless both bytes hold the unsecured pattern
	function automatic logic bytes_secure(input logic [7:0] b0, input logic [7:0] b1);
		bytes_secure = (b0 != `SEC_UNSECURE_BYTE) || (b1 != `SEC_UNSECURE_BYTE); // [RULE1]
	endfunction

	always_comb
	begin
		d = q;
		d.erase_req = 1'b0;
		d.rdata = 32'h0000_0000;
		d.recov_sel = (JTAG_IR == `IR_LOCKOUT);
		if (JTAG_DR_UPDATE && (JTAG_IR == `IR_LOCKOUT))
		begin
			d.div_shift = JTAG_DR_IN; // [RULE9]
		end
		case (q.st)
			ST_BOOT:
			begin
				// Evaluated once after reset, then frozen
				d.secure = bytes_secure(SEC_BYTE0, SEC_BYTE1); // [RULE2] [RULE3] [RULE6]
				d.st = ST_RUN;
			end
			ST_RUN:
			begin
				if (JTAG_RUN_ERASE && (JTAG_IR == `IR_LOCKOUT))
				begin
					d.div_hold = q.div_shift;
					d.erase_req = 1'b1; // [RULE8]
					d.st = ST_ERASE;
				end
			end
			ST_ERASE:
			begin
				if (ERASE_DONE)
				begin
					d.st = ST_DONE;
				end
			end
			ST_DONE:
			begin
				d.st = ST_DONE;
			end
			default:
			begin
				d.st = ST_BOOT;
			end
		endcase
		if (REG_RD)
		begin
			case (REG_ADDR)
				`SEC_STATUS_OFS:
				begin
					d.rdata[`STAT_SECURE_BIT] = q.secure;
					d.rdata[`STAT_RECOV_BIT] = q.recov_sel;
					d.rdata[`STAT_ERASING_BIT] = (q.st == ST_ERASE);
					d.rdata[`STAT_DONE_BIT] = (q.st == ST_DONE);
				end
				`SEC_DIVIDER_OFS:
				begin
					d.rdata[`DIV_WIDTH-1:0] = FLASH_DIVIDER;
				end
				`SEC_KEYS_OFS:
				begin
					d.rdata[15:0] = {SEC_BYTE1, SEC_BYTE0};
				end
				default:
				begin
					d.rdata = 32'h0000_0000;
				end
			endcase
		end
		// Software may acknowledge a finished erase; re-evaluation still waits for reset
		if (REG_WR && (REG_ADDR == `SEC_CTRL_OFS) && REG_WDATA[`CTRL_ERASE_DONE_BIT]
			&& (q.st == ST_DONE))
		begin
			d.st = ST_RUN;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			q.st <= ST_BOOT;
			q.secure <= 1'b1;
			q.recov_sel <= 1'b0;
			q.div_shift <= `DIV_RESET;
			q.div_hold <= `DIV_RESET;
			q.erase_req <= 1'b0;
			q.rdata <= 32'h0000_0000;
		end
		else if (CLK_EN)
		begin
			q <= d;
		end
	end

	// Secure held through reset until bytes are sampled
	assign DEBUG_READ_DISABLE = q.secure; // [RULE5] [RULE6]
	assign DEBUG_PORT_ENABLE = !q.secure; // [RULE4]
	assign TAP_ENABLE = 1'b1; // [RULE7]
	assign MASS_ERASE_REQ = q.erase_req;
	// Prescale in bit 6, divider in bits 5 to 0, straight through
	assign FLASH_DIVIDER = (q.recov_sel || (q.st == ST_ERASE)) ?
		((q.st == ST_ERASE) ? q.div_hold : q.div_shift) : NORMAL_DIVIDER; // [RULE11]
	assign REG_RDATA = q.rdata;

	// Assertions
	sequence erase_start_s;
		q.st == ST_RUN && JTAG_RUN_ERASE && JTAG_IR == `IR_LOCKOUT && CLK_EN;
	endsequence

	property erase_pulse_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		erase_start_s |=> MASS_ERASE_REQ ##1 !MASS_ERASE_REQ;
	endproperty

	secure_held_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE6]
		q.st != ST_BOOT |=> $stable(DEBUG_READ_DISABLE))
		else $error("Debug read disable changed after boot");
	secure_from_bytes_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE1]
		q.st == ST_BOOT && CLK_EN |=> DEBUG_READ_DISABLE == $past(bytes_secure(SEC_BYTE0, SEC_BYTE1)))
		else $error("Security state not taken from security bytes");
	port_modes_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE3]
		DEBUG_PORT_ENABLE != DEBUG_READ_DISABLE)
		else $error("Debug mode not exactly one of two");
	tap_active_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE7]
		TAP_ENABLE)
		else $error("JTAG port inactive");
	erase_pulse_a: assert property (erase_pulse_p) // [RULE8]
		else $error("Mass erase request not a single pulse");
	div_capture_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE9]
		CLK_EN && JTAG_DR_UPDATE && JTAG_IR == `IR_LOCKOUT |=> q.div_shift == $past(JTAG_DR_IN))
		else $error("Recovery divider not captured");
	div_replace_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE11]
		q.recov_sel && q.st == ST_RUN |-> FLASH_DIVIDER[`DIV_PRESCALE_BIT] == q.div_shift[6])
		else $error("Prescale bit not driven from recovery value");
	read_block_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // [RULE4]
		q.secure |-> !DEBUG_PORT_ENABLE)
		else $error("Debug port open while secured");

	// Steps of boot, erase and acknowledge
	sequence boot_edge_s;
		q.st == ST_BOOT && CLK_EN;
	endsequence

	sequence erase_busy_s;
		q.st == ST_ERASE;
	endsequence

	sequence done_seen_s;
		q.st == ST_ERASE && ERASE_DONE && CLK_EN;
	endsequence

	sequence ack_write_s;
		q.st == ST_DONE && CLK_EN && REG_WR && REG_ADDR == `SEC_CTRL_OFS
			&& REG_WDATA[`CTRL_ERASE_DONE_BIT];
	endsequence

	sequence done_stay_s;
		q.st == ST_DONE && CLK_EN && !(REG_WR && REG_ADDR == `SEC_CTRL_OFS
			&& REG_WDATA[`CTRL_ERASE_DONE_BIT]);
	endsequence

	sequence erase_refused_s;
		CLK_EN && JTAG_RUN_ERASE && (q.st != ST_RUN || JTAG_IR != `IR_LOCKOUT);
	endsequence

	// Register port reads and idle read cycles
	sequence status_read_s;
		CLK_EN && REG_RD && REG_ADDR == `SEC_STATUS_OFS;
	endsequence

	sequence keys_read_s;
		CLK_EN && REG_RD && REG_ADDR == `SEC_KEYS_OFS;
	endsequence

	sequence div_read_s;
		CLK_EN && REG_RD && REG_ADDR == `SEC_DIVIDER_OFS;
	endsequence

	sequence map_miss_s;
		CLK_EN && REG_RD && REG_ADDR != `SEC_STATUS_OFS
			&& REG_ADDR != `SEC_DIVIDER_OFS && REG_ADDR != `SEC_KEYS_OFS;
	endsequence

	sequence idle_bus_s;
		CLK_EN && !REG_RD;
	endsequence

	property boot_exit_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		boot_edge_s |=> q.st == ST_RUN;
	endproperty

	property erase_div_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		erase_busy_s |-> FLASH_DIVIDER == q.div_hold;
	endproperty

	property erase_finish_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		done_seen_s |=> q.st == ST_DONE;
	endproperty

	property done_ack_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		ack_write_s |=> q.st == ST_RUN;
	endproperty

	property done_sticky_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		done_stay_s |=> q.st == ST_DONE;
	endproperty

	property erase_refused_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		erase_refused_s |=> !MASS_ERASE_REQ;
	endproperty

	property erase_latch_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		erase_start_s |=> q.st == ST_ERASE && q.div_hold == $past(q.div_shift);
	endproperty

	property erase_origin_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		$rose(MASS_ERASE_REQ) |-> $past(q.st) == ST_RUN;
	endproperty

	property normal_div_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		!q.recov_sel && q.st != ST_ERASE |-> FLASH_DIVIDER == NORMAL_DIVIDER;
	endproperty

	property recov_track_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN |=> q.recov_sel == ($past(JTAG_IR) == `IR_LOCKOUT);
	endproperty

	property status_read_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		status_read_s |=> REG_RDATA[`STAT_SECURE_BIT] == $past(q.secure)
			&& REG_RDATA[`STAT_RECOV_BIT] == $past(q.recov_sel)
			&& REG_RDATA[`STAT_ERASING_BIT] == $past(q.st == ST_ERASE)
			&& REG_RDATA[`STAT_DONE_BIT] == $past(q.st == ST_DONE);
	endproperty

	property keys_read_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		keys_read_s |=> REG_RDATA == {16'h0000, $past(SEC_BYTE1), $past(SEC_BYTE0)};
	endproperty

	property div_read_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		div_read_s |=> REG_RDATA == {25'h0000000, $past(FLASH_DIVIDER)};
	endproperty

	property map_miss_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		map_miss_s |=> REG_RDATA == 32'h0000_0000;
	endproperty

	property idle_bus_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		idle_bus_s |=> REG_RDATA == 32'h0000_0000;
	endproperty

	property freeze_p;
		@(posedge CORE_CLK) disable iff (!RESET_N)
		!CLK_EN |=> $stable(q);
	endproperty

	boot_exit_a: assert property (boot_exit_p) // [RULE3]
		else $error("Boot evaluation did not finish in one cycle");
	erase_divider_a: assert property (erase_div_p) // [RULE11]
		else $error("Divider not held during erase");
	erase_finish_a: assert property (erase_finish_p) // [RULE8]
		else $error("Erase done not recorded");
	done_ack_a: assert property (done_ack_p) // [RULE8]
		else $error("Done acknowledge not taken");
	done_sticky_a: assert property (done_sticky_p) // [RULE8]
		else $error("Done state left without acknowledge");
	erase_refused_a: assert property (erase_refused_p) // [RULE8]
		else $error("Refused erase start raised a request");
	erase_latch_a: assert property (erase_latch_p) // [RULE9]
		else $error("Divider not latched at erase start");
	erase_origin_a: assert property (erase_origin_p) // [RULE8]
		else $error("Erase request raised outside run state");
	normal_divider_a: assert property (normal_div_p) // [RULE11]
		else $error("Normal divider not passed through");
	recov_track_a: assert property (recov_track_p) // [RULE9]
		else $error("Recovery select does not follow instruction");
	status_read_a: assert property (status_read_p) // [RULE3]
		else $error("Status read data wrong");
	keys_read_a: assert property (keys_read_p) // [RULE1]
		else $error("Security byte read data wrong");
	div_read_a: assert property (div_read_p) // [RULE11]
		else $error("Divider read data wrong");
	map_miss_a: assert property (map_miss_p)
		else $error("Unmapped read not zero");
	rdata_idle_a: assert property (idle_bus_p)
		else $error("Read data not zero outside its cycle");
	freeze_state_a: assert property (freeze_p)
		else $error("State moved while clock enable low");

endmodule // flash_secure

// ==== flash_secure_regs.svh ====
// Constants for the flash security and lockout recovery block
// Assumes inclusion by bare name from the package and module files
`ifndef FLASH_SECURE_REGS_SVH
`define FLASH_SECURE_REGS_SVH

// Register offsets (byte addresses, one word each)
`define SEC_CTRL_OFS        8'h00
`define SEC_STATUS_OFS      8'h04
`define SEC_DIVIDER_OFS     8'h08
`define SEC_KEYS_OFS        8'h0C

// Security byte value that means unsecured (each byte)
`define SEC_UNSECURE_BYTE   8'hFF

// Control register fields
`define CTRL_ERASE_DONE_BIT 0

// Status register fields
`define STAT_SECURE_BIT     0
`define STAT_RECOV_BIT      1
`define STAT_ERASING_BIT    2
`define STAT_DONE_BIT       3

// Recovery divider layout
`define DIV_WIDTH           7
`define DIV_PRESCALE_BIT    6
`define DIV_RESET           7'h00

// JTAG instruction code for lockout recovery
`define IR_WIDTH            4
`define IR_LOCKOUT          4'h5

`endif

// ==== flash_secure_pkg.sv ====
// Types for the flash security and lockout recovery block
// Assumes the constants header is on the include path
package flash_secure_pkg;
`include "flash_secure_regs.svh"

	typedef enum logic [1:0] {
		ST_BOOT,
		ST_RUN,
		ST_ERASE,
		ST_DONE
	} sec_state_t;

	typedef struct packed {
		sec_state_t             st;
		logic                   secure;
		logic                   recov_sel;
		logic [`DIV_WIDTH-1:0]  div_shift;
		logic [`DIV_WIDTH-1:0]  div_hold;
		logic                   erase_req;
		logic [31:0]            rdata;
	} sec_regs_t;

endpackage

// ==== recovery_host.sv ====
// Recovery host and flash erase engine model
// Assumes the shared core clock; drives after rising edges
`timescale 1ns/1ps
`include "flash_secure_regs.svh"

module recovery_host
	import flash_secure_pkg::*;
(
	// Clock
	input  wire logic                   clk,
	// Block side
	input  wire logic                   erase_req,
	output logic [`IR_WIDTH-1:0]        ir,
	output logic                        dr_upd,
	output logic [`DIV_WIDTH-1:0]       dr_in,
	output logic                        run,
	output logic                        done
);
	int req_cnt = 0;
	int lat = 3;
	int cnt = 0;
	initial {ir, dr_upd, dr_in, run, done} = '0;
	// Erase engine answers after lat cycles
	always @(posedge clk)
	begin
		done <= (cnt == 1);
		if (cnt > 0)
			cnt--;
		if (erase_req === 1'b1)
			cnt = lat;
		req_cnt += (erase_req === 1'b1);
	end
	// Divider first, then start, instruction held to the end
	task automatic recover(input logic [`DIV_WIDTH-1:0] v);
		@(posedge clk) ir <= `IR_LOCKOUT;
		@(posedge clk) {dr_upd, dr_in} <= {1'b1, v};
		@(posedge clk) {dr_upd, dr_in, run} <= {1'b0, ~v, 1'b1};
		@(posedge clk) run <= 1'b0;
		for (int i = 0; i < 40 && done !== 1'b1; i++)
			@(posedge clk);
	endtask
endmodule // recovery_host

// ==== tb.sv ====
// Self-checking bench for the flash security block
// Assumes the package and the recovery host model compile first
`timescale 1ns/1ps
`include "flash_secure_regs.svh"

module tb
	import flash_secure_pkg::*;
;
	logic clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, sec;
	logic [7:0] b0 = 8'hFF, b1 = 8'hFF, reg_addr = 8'h00;
	logic [31:0] reg_wdata = '0, rdata, reg_rdata;
	logic [6:0] norm_div = '0, fdiv, hdin, v;
	logic [3:0] hir;
	logic hupd, hrun, hdone, req, drd, dpe, tap;
	int error_cnt = 0, samples_checked = 0, seed = 2;

	flash_secure u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .SEC_BYTE0(b0),
		.SEC_BYTE1(b1), .JTAG_IR(hir), .JTAG_DR_UPDATE(hupd), .JTAG_DR_IN(hdin),
		.JTAG_RUN_ERASE(hrun), .NORMAL_DIVIDER(norm_div), .ERASE_DONE(hdone),
		.FLASH_DIVIDER(fdiv), .MASS_ERASE_REQ(req), .DEBUG_READ_DISABLE(drd),
		.DEBUG_PORT_ENABLE(dpe), .TAP_ENABLE(tap), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
	recovery_host u_host (.clk(clk), .erase_req(req), .ir(hir), .dr_upd(hupd),
		.dr_in(hdin), .run(hrun), .done(hdone));

	initial
		forever #50 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		@(negedge clk) rdata = reg_rdata;
	endtask
	task automatic boot;
		@(posedge clk) rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) sec = (b0 !== 8'hFF) || (b1 !== 8'hFF);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#500us;
		error_cnt++;
		close_out;
	end

	initial
	begin
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk) b0 <= (i % 3 == 1 || i == 0) ? 8'hFF : 8'($random(seed));
			b1 <= (i % 3 == 2 || i == 0) ? 8'hFF : 8'($random(seed));
			boot;
			chk(drd, sec);
			chk(dpe, !sec);
			chk(tap, 1'b1);
			rd(`SEC_STATUS_OFS);
			chk(rdata[0], sec);
			rd(`SEC_KEYS_OFS);
			chk(rdata, {16'h0, b1, b0});
			@(posedge clk) b0 <= b0 ^ 8'h01;
			repeat (3) @(posedge clk);
			chk(drd, sec);
		end
		$display("security boot test done");
		@(posedge clk) norm_div <= 7'($random(seed));
		@(negedge clk) chk(fdiv, norm_div);
		rd(8'h10);
		chk(rdata, 32'h0);
		@(posedge clk) {clk_en, reg_rd, reg_addr} <= {1'b0, 1'b1, `SEC_KEYS_OFS};
		@(posedge clk) reg_rd <= 1'b0;
		@(negedge clk) chk(reg_rdata, 32'h0);
		@(posedge clk) clk_en <= 1'b1;
		$display("divider and unmapped test done");
		@(posedge clk) b0 <= 8'h00;
		boot;
		v = 7'($random(seed));
		u_host.lat = 6;
		u_host.recover(v);
		@(negedge clk);
		chk(fdiv, v);
		rd(`SEC_DIVIDER_OFS);
		chk(rdata, {25'h0, v});
		rd(`SEC_STATUS_OFS);
		chk(rdata[3:0], 4'hB);
		chk(u_host.req_cnt, 1);
		u_host.recover(~v);
		chk(u_host.req_cnt, 1);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, `SEC_CTRL_OFS, 32'h1};
		@(posedge clk) reg_wr <= 1'b0;
		rd(`SEC_STATUS_OFS);
		chk(rdata[3:2], 2'b00);
		@(posedge clk) {b0, b1} <= 16'hFFFF;
		boot;
		chk(drd, 1'b0);
		$display("lockout recovery test done");
		close_out;
	end
endmodule // tb
